// ### spl_pkg.sv
// Constants shared by the strap latch and pin routing block
package spl_pkg;
    // Wishbone register byte offsets
    localparam logic [3:0]  SPL_OFS_BASE_LO   = 4'h0;
    localparam logic [3:0]  SPL_OFS_BASE_HI   = 4'h4;
    localparam logic [3:0]  SPL_OFS_ADC_GPIO  = 4'h8;
    localparam logic [3:0]  SPL_OFS_STATUS    = 4'hC;
    // Reset values of writable registers
    localparam logic [7:0]  SPL_BASE_LO_RST   = 8'h00;
    localparam logic [7:0]  SPL_BASE_HI_RST   = 8'h00;
    localparam logic [11:0] SPL_ADC_GPIO_RST  = 12'h000;
    // Fields of the analog pin control register
    localparam int          SPL_AG_SEL_LSB    = 0;
    localparam int          SPL_AG_OUT_LSB    = 4;
    localparam int          SPL_AG_OE_LSB     = 8;
    // Fields of the status register
    localparam int          SPL_ST_SHARE      = 0;
    localparam int          SPL_ST_PARPROG    = 1;
    localparam int          SPL_ST_BASE_LSB   = 2;
    localparam int          SPL_ST_VALID      = 4;
    localparam int          SPL_ST_GENERAL_INTERRUPT_PIN       = 5;
    localparam int          SPL_ST_GPIN_LSB   = 8;
    // Fixed configuration port pairs
    localparam logic [15:0] SPL_CFG_IDX_DEF   = 16'h002E;
    localparam logic [15:0] SPL_CFG_DAT_DEF   = 16'h002F;
    localparam logic [15:0] SPL_CFG_IDX_ALT   = 16'h004E;
    localparam logic [15:0] SPL_CFG_DAT_ALT   = 16'h004F;
    localparam logic [15:0] SPL_CFG_DAT_STEP  = 16'h0001;
    // Base strap bit positions
    localparam int          SPL_BASE_ALT_BIT  = 0;
    localparam int          SPL_BASE_REG_BIT  = 1;
endpackage

// ### spl_strap_route.sv
// Strap latch, configuration port decode and fixed pin routing
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Latch firmware share strap at power-up
// - Latch parallel program strap, reroute scan pins
// - No base strap: decode 002Eh and 002Fh
// - Low base strap: decode 004Eh and 004Fh
// - High base strap: pair from base registers
// - Interrupt pin feeds controller input 28
// - Upper analog pins usable as GPIO
// - Controller clock driven on clock output
// - Slow oscillator driven on slow output
module spl_strap_route
    import spl_pkg::*;
(
    // Clock and standby power-up reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Board straps
    input  wire logic        host_firmware_share_strap_i,
    input  wire logic        parallel_program_strap_i,
    input  wire logic [1:0]  config_port_base_strap_i,
    // Latched strap results
    output logic             share_enable_o,
    output logic             keyboard_scan_output_parport_o,
    output logic [1:0]       config_port_base_o,
    // Host I/O decode for the configuration space
    input  wire logic        host_io_i,
    input  wire logic [15:0] host_addr_i,
    output logic             cfg_index_hit_o,
    output logic             cfg_data_hit_o,
    // Interrupt routing
    input  wire logic        general_interrupt_pin_i,
    output logic             interrupt_controller_unit_input28_o,
    // Upper analog pins as GPIO
    input  wire logic [3:0]  adc_pin_i,
    output logic [3:0]       adc_pin_o,
    output logic [3:0]       adc_pin_oe_o,
    output logic [3:0]       adc_analog_en_o,
    // Clock outputs
    input  wire logic        slow_osc_i,
    output logic             controller_clock_output_o,
    output logic             slow_osc_output_o
);

    // Strap and routing state
    logic        valid_q, valid_d;
    logic        share_q, share_d;
    logic        par_q, par_d;
    logic [1:0]  base_q, base_d;
    logic [7:0]  blo_q, blo_d;
    logic [7:0]  bhi_q, bhi_d;
    logic [11:0] ag_q, ag_d;
    logic        idx_q, idx_d;
    logic        dat_q, dat_d;
    logic        int_q, int_d;
    logic        ck_q, ck_d;
    logic        slow_q, slow_d;
    logic        ack_q, ack_d;
    logic [31:0] rd_q, rd_d;
    logic [3:0]  gin_q, gin_d;
    logic [3:0]  oe_q, oe_d;
    logic [3:0]  aen_q, aen_d;
    logic [15:0] pair_idx;
    logic        wr_en;

    // Next-state logic for the whole block
    always_comb begin
        valid_d  = 1'b1;
        share_d  = share_q;
        par_d    = par_q;
        base_d   = base_q;
        blo_d    = blo_q;
        bhi_d    = bhi_q;
        ag_d     = ag_q;
        pair_idx = SPL_CFG_IDX_DEF;
        // Capture only on first cycle out of reset
        if (!valid_q) begin
            share_d = host_firmware_share_strap_i;
            par_d   = parallel_program_strap_i;
            base_d  = config_port_base_strap_i;
        end
        if (base_q[SPL_BASE_REG_BIT]) begin
            pair_idx = {bhi_q, blo_q};
        end else if (base_q[SPL_BASE_ALT_BIT]) begin
            pair_idx = SPL_CFG_IDX_ALT;
        end
        // Selected pair, blocked until straps are known
        idx_d = valid_q && host_io_i && (host_addr_i == pair_idx);
        dat_d = valid_q && host_io_i && (host_addr_i == pair_idx + SPL_CFG_DAT_STEP);
        // Straight route, one flop for a clean pin
        int_d  = general_interrupt_pin_i;
        // Toggle gives a half-rate controller clock
        ck_d   = ~ck_q;
        slow_d = slow_osc_i;
        gin_d  = adc_pin_i;
        // Single-cycle Wishbone answer, dropped the cycle after
        ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
        // Write lands on the edge where the master sees ack
        wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
        rd_d   = 32'h0000_0000;
        case (wb_adr_i)
            SPL_OFS_BASE_LO: begin
                rd_d[7:0] = blo_q;
                if (wr_en && wb_sel_i[0]) begin
                    blo_d = wb_dat_i[7:0];
                end
            end
            SPL_OFS_BASE_HI: begin
                rd_d[7:0] = bhi_q;
                if (wr_en && wb_sel_i[0]) begin
                    bhi_d = wb_dat_i[7:0];
                end
            end
            SPL_OFS_ADC_GPIO: begin
                rd_d[11:0] = ag_q;
                if (wr_en && wb_sel_i[0]) begin
                    ag_d[7:0] = wb_dat_i[7:0];
                end
                if (wr_en && wb_sel_i[1]) begin
                    ag_d[11:8] = wb_dat_i[11:8];
                end
            end
            SPL_OFS_STATUS: begin
                rd_d[SPL_ST_SHARE]                  = share_q;
                rd_d[SPL_ST_PARPROG]                = par_q;
                rd_d[SPL_ST_BASE_LSB +: 2]          = base_q;
                rd_d[SPL_ST_VALID]                  = valid_q;
                rd_d[SPL_ST_GENERAL_INTERRUPT_PIN]                   = int_q;
                rd_d[SPL_ST_GPIN_LSB +: 4]          = gin_q;
            end
            // Unmapped offsets read zero and drop writes
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
        // Pin drive and analog enable kept in flops, in step with control
        oe_d  = ag_d[SPL_AG_OE_LSB +: 4] & ag_d[SPL_AG_SEL_LSB +: 4];
        aen_d = ~ag_d[SPL_AG_SEL_LSB +: 4];
        if (!ack_d) begin
            rd_d = 32'h0000_0000;
        end
    end

    // State registers; straps only move while valid is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            share_q <= 1'b0;
            par_q   <= 1'b0;
            base_q  <= 2'h0;
            blo_q   <= SPL_BASE_LO_RST;
            bhi_q   <= SPL_BASE_HI_RST;
            ag_q    <= SPL_ADC_GPIO_RST;
            idx_q   <= 1'b0;
            dat_q   <= 1'b0;
            int_q   <= 1'b0;
            ck_q    <= 1'b0;
            slow_q  <= 1'b0;
            ack_q   <= 1'b0;
            rd_q    <= 32'h0000_0000;
            gin_q   <= 4'h0;
            oe_q    <= 4'h0;
            aen_q   <= 4'hF;
        end else begin
            valid_q <= valid_d;
            share_q <= share_d;
            par_q   <= par_d;
            base_q  <= base_d;
            blo_q   <= blo_d;
            bhi_q   <= bhi_d;
            ag_q    <= ag_d;
            idx_q   <= idx_d;
            dat_q   <= dat_d;
            int_q   <= int_d;
            ck_q    <= ck_d;
            slow_q  <= slow_d;
            ack_q   <= ack_d;
            rd_q    <= rd_d;
            gin_q   <= gin_d;
            oe_q    <= oe_d;
            aen_q   <= aen_d;
        end
    end

    // Outputs, all straight from flops
    assign wb_ack_o                       = ack_q;
    assign wb_dat_o                       = rd_q;
    assign share_enable_o                 = share_q;
    assign keyboard_scan_output_parport_o = par_q;
    assign config_port_base_o             = base_q;
    assign cfg_index_hit_o                = idx_q;
    assign cfg_data_hit_o                 = dat_q;
    assign interrupt_controller_unit_input28_o                 = int_q;
    // Selected channels become GPIO, others stay analog
    assign adc_pin_o                      = ag_q[SPL_AG_OUT_LSB +: 4];
    assign adc_pin_oe_o                   = oe_q;
    assign adc_analog_en_o                = aen_q;
    assign controller_clock_output_o      = ck_q;
    assign slow_osc_output_o              = slow_q;

    // Checks
    share_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !valid_q |=> share_enable_o == $past(host_firmware_share_strap_i))
        else $error("share strap not captured");
    par_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !valid_q |=> keyboard_scan_output_parport_o == $past(parallel_program_strap_i))
        else $error("program strap not captured");
    default_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_q && base_q == 2'h0 && host_io_i && host_addr_i == 16'h002F
        |=> cfg_data_hit_o && !cfg_index_hit_o)
        else $error("default pair missed");
    alt_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_q && base_q == 2'h1 && host_io_i && host_addr_i == 16'h004E
        |=> cfg_index_hit_o && !cfg_data_hit_o)
        else $error("alternate pair missed");
    reg_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_q && base_q[1] && host_io_i && host_addr_i == {bhi_q, blo_q}
        |=> cfg_index_hit_o)
        else $error("register pair missed");
    reg_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
        base_q == 2'h3 && {bhi_q, blo_q} != 16'h004E && host_addr_i == 16'h004E
        |=> !cfg_index_hit_o)
        else $error("fixed pair beat register pair");
    int_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 interrupt_controller_unit_input28_o == $past(general_interrupt_pin_i))
        else $error("interrupt route broken");
    gpio_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (adc_pin_oe_o & adc_analog_en_o) == 4'h0)
        else $error("pin driven while analog");
    clk_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        controller_clock_output_o |=> !controller_clock_output_o ##1 controller_clock_output_o)
        else $error("clock output stalled");
    slow_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 slow_osc_output_o == $past(slow_osc_i))
        else $error("slow clock route broken");
    strap_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        valid_q |=> $stable(share_enable_o) && $stable(config_port_base_o)
        && $stable(keyboard_scan_output_parport_o))
        else $error("latched strap moved");

endmodule // spl_strap_route

// ### spl_board_model.sv
// Board strap resistors and host configuration port access model
`timescale 1ns/1ps
module spl_board_model (
    // Strap fitting and host request from the bench
    input  wire logic        clk_i,
    input  wire logic [3:0]  pullup_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    // Pins toward the device
    output logic             share_o,
    output logic             parprog_o,
    output logic [1:0]       base_o,
    output logic             host_io_o,
    output logic [15:0]      host_addr_o
);
    logic [15:0] last_q = 16'h0000;
    assign {base_o, parprog_o, share_o} = pullup_i;
    // Remember last address so an idle bus never repeats it
    always_ff @(posedge clk_i) begin
        if (req_i) last_q <= addr_i;
    end
    assign host_io_o   = req_i;
    assign host_addr_o = req_i ? addr_i : ~last_q;
endmodule // spl_board_model

// ### tb.sv
// Self-checking bench for the strap latch and pin routing block
`timescale 1ns/1ps
module tb
    import spl_pkg::*;
;
    logic        clk, rst, cyc, stb, we, req, irq_pin, osc, ck, ack, sh_pin, pp_pin, hio;
    logic        share, parport, hit_i, hit_d, interrupt_controller_unit, slow, ckout;
    logic [3:0]  adr, sel, pull, ain, aout, aoe, aen;
    logic [31:0] wdat, rdat, rd;
    logic [15:0] addr, haddr, cbase, ix;
    logic [11:0] v;
    logic [1:0]  bpin, bout;
    int          errors, total_checks;

    spl_strap_route dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .host_firmware_share_strap_i(sh_pin), .parallel_program_strap_i(pp_pin),
        .config_port_base_strap_i(bpin), .share_enable_o(share),
        .keyboard_scan_output_parport_o(parport), .config_port_base_o(bout),
        .host_io_i(hio), .host_addr_i(haddr), .cfg_index_hit_o(hit_i), .cfg_data_hit_o(hit_d),
        .general_interrupt_pin_i(irq_pin), .interrupt_controller_unit_input28_o(interrupt_controller_unit), .adc_pin_i(ain),
        .adc_pin_o(aout), .adc_pin_oe_o(aoe), .adc_analog_en_o(aen), .slow_osc_i(osc),
        .controller_clock_output_o(ckout), .slow_osc_output_o(slow));
    spl_board_model board (.clk_i(clk), .pullup_i(pull), .req_i(req), .addr_i(addr),
        .share_o(sh_pin), .parprog_o(pp_pin), .base_o(bpin), .host_io_o(hio),
        .host_addr_o(haddr));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("unexpected at %0t: ack got %h expected %h", $time, ack, 1'b1);
        end
        @(posedge clk);
    endtask

    // One host cycle, then both hit flags compared against the expected pair
    task automatic probe(input logic [15:0] a, input logic [15:0] idx);
        req <= 1'b1;
        addr <= a;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        chk({hit_i, hit_d}, {30'h0, a == idx, a == idx + 16'h0001});
    endtask

    // Register pair wins when the upper strap is fitted
    function automatic logic [15:0] exp_idx(input logic [1:0] b, input logic [15:0] r);
        if (b[1]) return r;
        if (b[0]) return 16'h004E;
        return 16'h002E;
    endfunction

    initial begin
        #1_000_000;
        errors++;
        $display("unexpected at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
        end_sim();
    end

    initial begin
        {rst, cyc, stb, we, req, irq_pin, osc} = 7'h01 << 6;
        {adr, sel, pull, ain, wdat, addr} = '0;
        errors = 0;
        total_checks = 0;
        void'($urandom(32'hDDA5));
        // Every strap combination, changed again after capture
        for (int s = 0; s < 16; s++) begin
            rst <= 1'b1;
            pull <= 4'(s);
            repeat (16) @(posedge clk);
            rst <= 1'b0;
            repeat (2) @(posedge clk);
            pull <= ~4'(s);
            cbase = 16'($urandom);
            wb(1'b0, SPL_OFS_BASE_HI, 4'hF, 32'h0);
            chk(rd, 32'h0);
            wb(1'b1, SPL_OFS_BASE_LO, 4'hF, {24'h0, cbase[7:0]});
            wb(1'b1, SPL_OFS_BASE_HI, 4'hF, {24'h0, cbase[15:8]});
            chk({share, parport, bout}, {28'h0, s[0], s[1], s[3:2]});
            wb(1'b0, SPL_OFS_STATUS, 4'hF, 32'h0);
            chk(rd[4:0], {1'b1, s[3:2], s[1], s[0]});
            ix = exp_idx(s[3:2], cbase);
            probe(16'h002E, ix);
            probe(16'h002F, ix);
            probe(16'h004E, ix);
            probe(16'h004F, ix);
            probe(cbase, ix);
            probe(cbase + 16'h0001, ix);
            $display("strap test %0d done", s);
        end
        // Fixed routes with random levels
        repeat (40) begin
            @(posedge clk);
            irq_pin <= 1'($urandom);
            osc <= 1'($urandom);
            #1 ck = ckout;
            @(posedge clk);
            #1 chk(interrupt_controller_unit, irq_pin);
            chk(slow, osc);
            chk(ckout, {31'h0, ~ck});
        end
        @(posedge clk);
        $display("route test done");
        // Analog pins as GPIO, lane 1 left alone on the second write
        repeat (8) begin
            v = 12'($urandom);
            ain <= 4'($urandom);
            wb(1'b1, SPL_OFS_ADC_GPIO, 4'h3, {20'h0, v});
            chk({aout, aoe, aen}, {20'h0, v[7:4], v[11:8] & v[3:0], ~v[3:0]});
            wb(1'b1, SPL_OFS_ADC_GPIO, 4'h1, 32'h0);
            wb(1'b0, SPL_OFS_ADC_GPIO, 4'hF, 32'h0);
            chk(rd, {20'h0, v[11:8], 8'h00});
            wb(1'b0, SPL_OFS_STATUS, 4'hF, 32'h0);
            chk(rd[11:8], ain);
        end
        wb(1'b0, 4'h2, 4'hF, 32'h0);
        chk(rd, 32'h0);
        $display("analog test done");
        end_sim();
    end
endmodule // tb
